// >>> bench/bbs_decode_assertions.sv
/*
 bbs_decode_assertions: handshake and answer-time checks on the bus ports of bbs_decode.
 Assumes it is bound onto bbs_decode, one clock aclk, synchronous active-low aresetn.
*/
`timescale 1ns/10ps
`include "bbs_decode_regs.vh"

module bbs_decode_assertions (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_aw_one_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready high two cycles");
    a_aw_needs_valid: assert property (s_axi_awready |-> s_axi_awvalid)
        else $error("awready without awvalid");
    a_w_one_pulse: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready high two cycles");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed");
    // an instruction in flight delays the write answer by at most two instruction cycles
    a_b_bounded: assert property (s_aw_taken |-> ##[1:14] s_axi_bvalid)
        else $error("write answer late");
    a_r_bounded: assert property (s_ar_taken |-> ##[1:4] s_axi_rvalid)
        else $error("read answer late");
    a_r_unmapped: assert property (s_ar_taken ##0 (s_axi_araddr > 8'h1C || s_axi_araddr[1:0] != 2'h0)
        |-> ##[1:4] (s_axi_rvalid && s_axi_rresp == `BBS_RESP_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
endmodule

bind bbs_decode bbs_decode_assertions u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

// >>> bench/test_bbs_decode.sv
/*
 test_bbs_decode: self-checking bench for bbs_decode, driving its bus as master.
 Assumes the register map and constants of bbs_decode_regs.vh.
*/
`timescale 1ns/10ps
`include "bbs_decode_regs.vh"
`define CHK(nm, e, g) \
    begin \
        tests_run = tests_run + 1; \
        if ((g) !== (e)) \
        begin \
            num_errors = num_errors + 1; \
            $display("wrong value %0s expected %0h seen %0h", nm, e, g); \
        end \
    end

module test_bbs_decode;
    reg aclk = 0;
    reg aresetn = 0;
    reg [7:0] s_axi_awaddr = 0;
    reg s_axi_awvalid = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [3:0] s_axi_wstrb = 0;
    reg s_axi_wvalid = 0;
    reg s_axi_bready = 0;
    reg [7:0] s_axi_araddr = 0;
    reg s_axi_arvalid = 0;
    reg s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer num_errors = 0;
    integer tests_run = 0;
    integer i, k, n, base;
    reg [31:0] rdv;
    reg [1:0] rsp, st;
    reg [15:0] ins;
    reg [20:0] pc;
    reg [21:0] ex;
    reg [7:0] o8, f, d;
    reg [10:0] o11;
    reg [2:0] b;
    reg [3:0] bk;
    reg [11:0] ix;
    reg a, ext;

    always #50 aclk = ~aclk;

    bbs_decode uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    task end_of_test;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    task hang;
    begin
        num_errors = num_errors + 1;
        $display("wrong value handshake expected answer seen none");
        end_of_test;
    end
    endtask

    // n returns the cycles from offering the write to its answer
    task wr(input [7:0] ad, input [31:0] dat, output [1:0] r);
    begin
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dat;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 60; k = k + 1)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                n = k + 1;
                k = 99;
            end
        end
        if (k != 100)
            hang;
    end
    endtask

    task rd(input [7:0] ad, output [31:0] dat, output [1:0] r);
    begin
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 60; k = k + 1)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                dat = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                k = 99;
            end
        end
        if (k != 100)
            hang;
    end
    endtask

    task wo(input [7:0] ad, input [31:0] dat);
    begin
        wr(ad, dat, rsp);
        `CHK("bresp", `BBS_RESP_OKAY, rsp)
    end
    endtask

    task rc(input [7:0] ad, input [31:0] e, input [8*6-1:0] nm);
    begin
        rd(ad, rdv, rsp);
        `CHK(nm, e, rdv)
    end
    endtask

    // returns {taken, next pc}
    function [21:0] f_br(input [20:0] p, input [15:0] w, input [1:0] s);
        reg t;
        reg [20:0] off;
    begin
        off = {{13{w[7]}}, w[7:0]};
        t = 1'b0;
        if (w[15:8] == 8'hE5)
            t = !s[1];
        if (w[15:8] == 8'hE1)
            t = !s[0];
        if (w[15:11] == 5'h1A)
        begin
            t = 1'b1;
            off = {{10{w[10]}}, w[10:0]};
        end
        f_br = {t, t ? p + 21'h2 + (off << 1) : p + 21'h2};
    end
    endfunction

    function [11:0] f_ad(input [7:0] fr, input ac, input x, input [3:0] bnk, input [11:0] bs);
    begin
        if (ac)
            f_ad = {bnk, fr};
        else if (x && fr <= 8'h5F)
            f_ad = bs + fr;
        else
            f_ad = {fr[7] ? 4'hF : 4'h0, fr};
    end
    endfunction

    initial
    begin
        i = $urandom(22);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`BBS_OFF_PC, 32'h0, "pc");
        rc(`BBS_OFF_STATUS, 32'h0, "status");
        rd(8'h20, rdv, rsp);
        `CHK("rresp", `BBS_RESP_SLVERR, rsp)
        `CHK("rdata", 32'h0, rdv)
        rd(8'h06, rdv, rsp);
        `CHK("rresp", `BBS_RESP_SLVERR, rsp)
        wr(8'h24, 32'h1, rsp);
        `CHK("bresp", `BBS_RESP_SLVERR, rsp)
        // untaken branch sets the reference time for the flush cycle
        wo(`BBS_OFF_STATUS, 32'h2);
        wo(`BBS_OFF_INSTR, 32'hE500);
        wr(`BBS_OFF_CTRL, 32'h0, rsp);
        base = n;
        for (i = 0; i < 36; i = i + 1)
        begin
            o8 = $urandom;
            o11 = $urandom;
            st = $urandom;
            pc = $urandom & 21'h1FFFFE;
            if (i < 6)
            begin
                st = 2'h0;
                o8 = (i < 3) ? 8'h80 : 8'h7F;
                o11 = (i < 3) ? 11'h400 : 11'h3FF;
            end
            case (i % 3)
                0: ins = {8'hE5, o8};
                1: ins = {8'hE1, o8};
                default: ins = {5'h1A, o11};
            endcase
            ex = f_br(pc, ins, st);
            wo(`BBS_OFF_STATUS, {30'h0, st});
            wo(`BBS_OFF_PC, {11'h0, pc});
            wo(`BBS_OFF_INSTR, {16'h0, ins});
            wr(`BBS_OFF_CTRL, 32'h0, rsp);
            `CHK("cycles", base + 4 * ex[21], n)
            rc(`BBS_OFF_PC, {11'h0, ex[20:0]}, "pc");
            rc(`BBS_OFF_STATUS, {22'h0, ex[21], 7'h0, st}, "status");
        end
        // an opcode outside the four only steps the pc and sets the sticky status bit
        wo(`BBS_OFF_STATUS, 32'h0);
        wo(`BBS_OFF_PC, 32'h100);
        wo(`BBS_OFF_INSTR, 32'h0);
        rc(`BBS_OFF_PC, 32'h102, "pc");
        rc(`BBS_OFF_STATUS, 32'h400, "status");
        for (i = 0; i < 15; i = i + 1)
        begin
            f = $urandom;
            b = $urandom;
            bk = $urandom;
            ix = $urandom;
            d = $urandom;
            st = $urandom;
            a = (i % 5 == 0);
            ext = (i % 5 >= 3);
            if (i % 5 == 1)
                f[7] = 1'b0;
            if (i % 5 == 2)
                f[7] = 1'b1;
            if (i % 5 == 3)
                f = (i < 5) ? 8'h5F : f % 8'h60;
            if (i % 5 == 4)
                f = (i < 5) ? 8'h60 : 8'h60 + f % 8'hA0;
            wo(`BBS_OFF_CTRL, {31'h0, ext});
            wo(`BBS_OFF_BANK, {28'h0, bk});
            wo(`BBS_OFF_INDEX, {20'h0, ix});
            wo(`BBS_OFF_MADDR, {20'h0, f_ad(f, a, ext, bk, ix)});
            wo(`BBS_OFF_MDATA, {24'h0, d});
            wo(`BBS_OFF_STATUS, {30'h0, st});
            wo(`BBS_OFF_INSTR, {16'h0, 4'h8, b, a, f});
            rc(`BBS_OFF_MDATA, {24'h0, d | (8'h1 << b)}, "mdata");
            rc(`BBS_OFF_STATUS, {30'h0, st}, "status");
        end
        end_of_test;
    end
endmodule

// >>> pkg/bbs_decode_regs.vh
/*
 bbs_decode_regs.vh: register offsets, field positions, reset values, opcodes and
 phase constants of the branch and bit-set decode block.
 Assumes it is included by its bare name from the design files of this block.
*/
`ifndef BBS_DECODE_REGS_VH
`define BBS_DECODE_REGS_VH

// register byte offsets on the 8-bit AXI4-Lite address
`define BBS_OFF_CTRL 8'h00
`define BBS_OFF_INSTR 8'h04
`define BBS_OFF_PC 8'h08
`define BBS_OFF_STATUS 8'h0C
`define BBS_OFF_BANK 8'h10
`define BBS_OFF_INDEX 8'h14
`define BBS_OFF_MADDR 8'h18
`define BBS_OFF_MDATA 8'h1C

// field positions
`define BBS_CTRL_EXT 0
`define BBS_ST_ZERO 0
`define BBS_ST_OVF 1
`define BBS_ST_BUSY 8
`define BBS_ST_TAKEN 9
`define BBS_ST_ILLEGAL 10

// reset values
`define BBS_RST_PC 21'h000000
`define BBS_RST_BANK 4'h0
`define BBS_RST_INDEX 12'h000
`define BBS_RST_MADDR 12'h000
`define BBS_RST_INSTR 16'h0000

// instruction encodings
`define BBS_OPC_NO_OVF 8'hE5
`define BBS_OPC_NONZERO 8'hE1
`define BBS_OPC_JUMP 5'h1A
`define BBS_OPC_BITSET 4'h8

// access bank layout and indexed literal offset limit
`define BBS_ACC_SPLIT 8'h80
`define BBS_ACC_LOW_BANK 4'h0
`define BBS_ACC_HIGH_BANK 4'hF
`define BBS_IDX_LIMIT 8'h5F

// program counter step and phase numbering
`define BBS_PC_STEP 21'h000002
`define BBS_PH_Q1 2'h0
`define BBS_PH_Q2 2'h1
`define BBS_PH_Q3 2'h2
`define BBS_PH_Q4 2'h3

// AXI responses
`define BBS_RESP_OKAY 2'h0
`define BBS_RESP_SLVERR 2'h2

`endif

// >>> verilog/bbs_decode.v
/*
 bbs_decode: decode and execute of three relative branches and one bit-set
 instruction, each instruction cycle split in four clock phases, with an
 AXI4-Lite register slave and the data-memory file behind it.
 Assumes a single 10 MHz clock aclk, synchronous active-low aresetn, and a bus
 master that keeps its valid and payload steady until each handshake.
*/
// Local design decisions: the address map and the AXI4-Lite register port.
// Notes on behaviour
// RL1 - E5 opcode branches when overflow clear
// RL2 - E1 opcode branches when zero clear
// RL3 - taken target is old pc plus 2+2n
// RL4 - one cycle untaken, taken adds nop cycle
// RL5 - 11010 prefix jumps always, two cycles
// RL6 - bit set: read Q2, write Q4, flags kept
// RL7 - access bit picks access or banked address
// RL8 - extended mode indexes when f up to 5F
// RL9 - flags sampled at decode, branches keep flags
`timescale 1ns/10ps
`include "bbs_decode_regs.vh"

module bbs_decode (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam S_IDLE = 2'h0, S_EXEC = 2'h1, S_FLUSH = 2'h2;
    localparam K_NONE = 3'h0, K_NO_OVF = 3'h1, K_NONZERO = 3'h2, K_JUMP = 3'h3, K_BITSET = 3'h4;

    reg ext_en, flag_zero, flag_ovf, last_taken, illegal, taken;
    reg aw_got, w_got, ar_got, q_fresh;
    reg [15:0] instr;
    reg [20:0] pc, target;
    reg [3:0] bank_select_reg, w_strb;
    reg [11:0] index_base, mem_addr, file_addr;
    reg [1:0] state, phase;
    reg [2:0] kind;
    reg [7:0] new_byte, aw_addr, rd_addr;
    reg [31:0] w_data;
    wire [7:0] mem_q;
    wire [2:0] dec_kind;
    wire wr_fire, bus_mem_we, exec_mem_we;
    wire [31:0] wr_merged;
    wire [11:0] mem_addr_mux;
    wire [20:0] offset;

    function [2:0] bbs_kind;
        input [15:0] word;
        begin
            if (word[15:8] == `BBS_OPC_NO_OVF)
                bbs_kind = K_NO_OVF; // RL1
            else if (word[15:8] == `BBS_OPC_NONZERO)
                bbs_kind = K_NONZERO; // RL2
            else if (word[15:11] == `BBS_OPC_JUMP)
                bbs_kind = K_JUMP; // RL5
            else if (word[15:12] == `BBS_OPC_BITSET)
                bbs_kind = K_BITSET; // RL6
            else
                bbs_kind = K_NONE;
        end
    endfunction
    function [11:0] bbs_file_address;
        input [7:0] f;
        input a;
        input ext;
        input [3:0] bank;
        input [11:0] base;
        begin
            if (a)
                bbs_file_address = {bank, f}; // RL7
            else if (ext && (f <= `BBS_IDX_LIMIT))
                bbs_file_address = base + {4'h0, f}; // RL8
            else if (f < `BBS_ACC_SPLIT)
                bbs_file_address = {`BBS_ACC_LOW_BANK, f}; // RL7
            else
                bbs_file_address = {`BBS_ACC_HIGH_BANK, f}; // RL7
        end
    endfunction
    // byte-lane merge of a write into the old register value
    function [31:0] bbs_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            bbs_merge = old;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (strb[i])
                    bbs_merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction
    // the map is one aligned word per register, from CTRL up to MDATA without gaps
    function bbs_mapped;
        input [7:0] a;
        begin
            bbs_mapped = (a[1:0] == 2'h0) && (a <= `BBS_OFF_MDATA);
        end
    endfunction
    // register view; reserved bits and unmapped addresses read zero
    function [31:0] bbs_view;
        input [7:0] a;
        begin
            bbs_view = 32'h00000000;
            case (a)
                `BBS_OFF_CTRL: bbs_view[`BBS_CTRL_EXT] = ext_en;
                `BBS_OFF_INSTR: bbs_view[15:0] = instr;
                `BBS_OFF_PC: bbs_view[20:0] = pc;
                `BBS_OFF_STATUS:
                begin
                    bbs_view[`BBS_ST_ZERO] = flag_zero;
                    bbs_view[`BBS_ST_OVF] = flag_ovf;
                    bbs_view[`BBS_ST_BUSY] = (state != S_IDLE);
                    bbs_view[`BBS_ST_TAKEN] = last_taken;
                    bbs_view[`BBS_ST_ILLEGAL] = illegal;
                end
                `BBS_OFF_BANK: bbs_view[3:0] = bank_select_reg;
                `BBS_OFF_INDEX: bbs_view[11:0] = index_base;
                `BBS_OFF_MADDR: bbs_view[11:0] = mem_addr;
                `BBS_OFF_MDATA: bbs_view[7:0] = mem_q;
                default: bbs_view = 32'h00000000;
            endcase
        end
    endfunction
    assign dec_kind = bbs_kind(instr);
    // writes wait while an instruction runs, so bus and core never race on state
    assign wr_fire = aw_got && w_got && !s_axi_bvalid && (state == S_IDLE);
    assign wr_merged = bbs_merge(bbs_view(aw_addr), w_data, w_strb);
    assign bus_mem_we = wr_fire && (aw_addr == `BBS_OFF_MDATA);
    assign exec_mem_we = (state == S_EXEC) && (phase == `BBS_PH_Q4) && (kind == K_BITSET); // RL6
    assign mem_addr_mux = (state == S_EXEC) ? file_addr : mem_addr;
    assign offset = (kind == K_JUMP) ? {{9{instr[10]}}, instr[10:0], 1'b0}
                                     : {{12{instr[7]}}, instr[7:0], 1'b0}; // RL3
    bbs_file_mem u_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .addr(mem_addr_mux),
        .we(bus_mem_we || exec_mem_we),
        .wdata(exec_mem_we ? new_byte : wr_merged[7:0]),
        .rdata(mem_q)
    );

    // AXI4-Lite channel handshakes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BBS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `BBS_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            ar_got <= 1'b0;
            rd_addr <= 8'h00;
            q_fresh <= 1'b0;
        end
        else
        begin
            if (s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (s_axi_awvalid && !aw_got)
                s_axi_awready <= 1'b1;
            if (s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (s_axi_wvalid && !w_got)
                s_axi_wready <= 1'b1;
            if (wr_fire)
            begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bbs_mapped(aw_addr) ? `BBS_RESP_OKAY : `BBS_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                ar_got <= 1'b1;
                rd_addr <= s_axi_araddr;
            end
            else if (s_axi_arvalid && !ar_got && !s_axi_rvalid)
                s_axi_arready <= 1'b1;
            // memory data is only returned once the read register holds mem_addr
            if (ar_got && ((rd_addr != `BBS_OFF_MDATA) || q_fresh))
            begin
                ar_got <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= bbs_view(rd_addr);
                s_axi_rresp <= bbs_mapped(rd_addr) ? `BBS_RESP_OKAY : `BBS_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            q_fresh <= (state != S_EXEC) && !bus_mem_we
                       && !(wr_fire && (aw_addr == `BBS_OFF_MADDR));
        end
    end

    // software registers and the four-phase execute sequence
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_en <= 1'b0;
            instr <= `BBS_RST_INSTR;
            pc <= `BBS_RST_PC;
            flag_zero <= 1'b0;
            flag_ovf <= 1'b0;
            last_taken <= 1'b0;
            illegal <= 1'b0;
            bank_select_reg <= `BBS_RST_BANK;
            index_base <= `BBS_RST_INDEX;
            mem_addr <= `BBS_RST_MADDR;
            state <= S_IDLE;
            phase <= `BBS_PH_Q1;
            kind <= K_NONE;
            taken <= 1'b0;
            file_addr <= 12'h000;
            target <= `BBS_RST_PC;
            new_byte <= 8'h00;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (wr_fire)
                        case (aw_addr)
                            `BBS_OFF_CTRL: ext_en <= wr_merged[`BBS_CTRL_EXT];
                            `BBS_OFF_INSTR:
                            begin
                                instr <= wr_merged[15:0];
                                state <= S_EXEC;
                                phase <= `BBS_PH_Q1;
                            end
                            `BBS_OFF_PC: pc <= wr_merged[20:0];
                            `BBS_OFF_STATUS:
                            begin
                                flag_zero <= wr_merged[`BBS_ST_ZERO];
                                flag_ovf <= wr_merged[`BBS_ST_OVF];
                                last_taken <= wr_merged[`BBS_ST_TAKEN];
                                illegal <= wr_merged[`BBS_ST_ILLEGAL];
                            end
                            `BBS_OFF_BANK: bank_select_reg <= wr_merged[3:0];
                            `BBS_OFF_INDEX: index_base <= wr_merged[11:0];
                            `BBS_OFF_MADDR: mem_addr <= wr_merged[11:0];
                            default: ext_en <= ext_en;
                        endcase
                end
                S_EXEC:
                begin
                    phase <= phase + 2'h1;
                    case (phase)
                        `BBS_PH_Q1:
                        begin
                            // decode; the pc still points at this one-word instruction and is stepped past it here
                            pc <= pc + `BBS_PC_STEP; // RL3
                            kind <= dec_kind;
                            // flags as left by the previous instruction, never altered here
                            taken <= ((dec_kind == K_NO_OVF) && !flag_ovf)
                                     || ((dec_kind == K_NONZERO) && !flag_zero)
                                     || (dec_kind == K_JUMP); // RL1 RL2 RL5 RL9
                            file_addr <= bbs_file_address(instr[7:0], instr[8], ext_en,
                                                          bank_select_reg, index_base); // RL7 RL8
                            if (dec_kind == K_NONE)
                                illegal <= 1'b1;
                        end
                        `BBS_PH_Q3:
                        begin
                            target <= pc + offset; // RL3 RL5
                            new_byte <= mem_q | (8'h01 << instr[11:9]); // RL6
                        end
                        `BBS_PH_Q4:
                        begin
                            if (taken)
                            begin
                                pc <= target; // RL3 RL4
                                state <= S_FLUSH; // RL4 RL5
                            end
                            else
                                state <= S_IDLE; // RL4
                            last_taken <= taken;
                        end
                        default: phase <= phase + 2'h1;
                    endcase
                end
                S_FLUSH:
                begin
                    // second instruction cycle of a taken branch does nothing
                    phase <= phase + 2'h1;
                    if (phase == `BBS_PH_Q4)
                        state <= S_IDLE; // RL4
                end
                default:
                begin
                    state <= S_IDLE;
                    phase <= `BBS_PH_Q1;
                end
            endcase
        end
    end

endmodule

// >>> verilog/bbs_file_mem.v
/*
 bbs_file_mem: 4096 x 8 data-memory file with one write port and one read port
 whose data comes out of a register one clock after the address.
 Assumes a single clock and a synchronous active-low reset that clears only the
 read register; the array contents are undefined until written.
*/
`timescale 1ns/10ps

module bbs_file_mem (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] addr,
    input wire we,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);

    reg [7:0] cells [0:4095];

    // read-before-write: a read of the address being written returns the old byte
    always @(posedge aclk)
    begin
        if (we)
        begin
            cells[addr] <= wdata;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= cells[addr];
        end
    end

endmodule
